// File: core/pmr_regmap.sv
// Register map of the supply: status word, output switch, measurements, targets, current trip
`include "pmr_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module pmr_regmap #(
    parameter int TRIP_SAMPLES = `PMR_TRIP_SAMPLES,
    parameter int FLAG_W       = 64
) (
    input  wire logic              clk_sys_i,
    input  wire logic              arst_n_i,
    input  wire logic              req_valid_i,
    input  wire pmr_pkg::pmr_req_t req_i,
    output logic                   rsp_valid_o,
    output pmr_pkg::pmr_rsp_t      rsp_o,
    input  wire logic [FLAG_W-1:0] plant_flags_i,
    input  wire logic              sense_engaged_i,
    input  wire logic              meas_valid_i,
    input  wire pmr_pkg::pmr_meas_t meas_i,
    output logic                   power_enable_o
);

    localparam int PIN_W = FLAG_W + 1;
    localparam int CNT_W = $clog2(TRIP_SAMPLES + 1);
    localparam logic [CNT_W-1:0] TRIP_LAST = CNT_W'(TRIP_SAMPLES - 1);

    // ------------------------------------------------------------------------
    // Request decoding
    // ------------------------------------------------------------------------
    function automatic pmr_pkg::pmr_dec_t decode_req(input pmr_pkg::pmr_req_t r);
        pmr_pkg::pmr_dec_t d;
        logic [7:0]        fc_exp;
        logic [15:0]       cnt_exp;
        d.exc_code = `PMR_EXC_NONE;
        fc_exp     = `PMR_FC_READ_HOLD;
        cnt_exp    = `PMR_CNT_VALUE;
        unique case (r.addr)
            `PMR_ADDR_STATUS:    begin d.tgt = pmr_pkg::TGT_STATUS;    cnt_exp = `PMR_CNT_STATUS; end
            `PMR_ADDR_OUT_WR:    begin d.tgt = pmr_pkg::TGT_OUT_WR;    fc_exp = `PMR_FC_WRITE_SINGLE; end
            `PMR_ADDR_OUT_RD:    begin d.tgt = pmr_pkg::TGT_OUT_RD;    cnt_exp = `PMR_CNT_SINGLE; end
            `PMR_ADDR_MEAS_CURR: d.tgt = pmr_pkg::TGT_MEAS_CURR;
            `PMR_ADDR_MEAS_VOLT: d.tgt = pmr_pkg::TGT_MEAS_VOLT;
            `PMR_ADDR_MEAS_PWR:  d.tgt = pmr_pkg::TGT_MEAS_PWR;
            `PMR_ADDR_CURR_WR:   begin d.tgt = pmr_pkg::TGT_CURR_WR;   fc_exp = `PMR_FC_WRITE_MULTI; end
            `PMR_ADDR_CURR_RD:   d.tgt = pmr_pkg::TGT_CURR_RD;
            `PMR_ADDR_VOLT_WR:   begin d.tgt = pmr_pkg::TGT_VOLT_WR;   fc_exp = `PMR_FC_WRITE_MULTI; end
            `PMR_ADDR_VOLT_RD:   d.tgt = pmr_pkg::TGT_VOLT_RD;
            `PMR_ADDR_PWR_WR:    begin d.tgt = pmr_pkg::TGT_PWR_WR;    fc_exp = `PMR_FC_WRITE_MULTI; end
            `PMR_ADDR_PWR_RD:    d.tgt = pmr_pkg::TGT_PWR_RD;
            `PMR_ADDR_TRIP_WR:   begin d.tgt = pmr_pkg::TGT_TRIP_WR;   fc_exp = `PMR_FC_WRITE_MULTI; end
            `PMR_ADDR_TRIP_RD:   d.tgt = pmr_pkg::TGT_TRIP_RD;
            default:             d.tgt = pmr_pkg::TGT_NONE;
        endcase
        if (r.func != `PMR_FC_READ_HOLD && r.func != `PMR_FC_WRITE_SINGLE && r.func != `PMR_FC_WRITE_MULTI) begin
            d.exc_code = `PMR_EXC_FUNC;
        end else if (d.tgt == pmr_pkg::TGT_NONE || r.func != fc_exp) begin
            d.exc_code = `PMR_EXC_ADDR;
        end else if (r.func == `PMR_FC_WRITE_SINGLE) begin
            if (r.wdata[15:0] != `PMR_OUT_OFF && r.wdata[15:0] != `PMR_OUT_ON) begin
                d.exc_code = `PMR_EXC_VALUE;
            end
        end else if (r.count != cnt_exp) begin
            d.exc_code = `PMR_EXC_VALUE;
        end
        return d;
    endfunction

    // Ordered float compare, a above b
    function automatic logic fp_above(input logic [31:0] a, input logic [31:0] b);
        if (a[31] != b[31]) begin
            return !a[31] && ((a[30:0] | b[30:0]) != 31'h0000_0000);
        end
        return a[31] ? (a[30:0] < b[30:0]) : (a[30:0] > b[30:0]);
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [PIN_W-1:0] pin_s1_reg;
    logic [PIN_W-1:0] pin_s2_reg;
    logic [PIN_W-1:0] pin_s3_reg;
    logic [PIN_W-1:0] pin_filt_reg;
    logic [PIN_W-1:0] pin_filt_next;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin
            always_comb begin
                pin_filt_next[gi] = (pin_s2_reg[gi] == pin_s3_reg[gi]) ? pin_s2_reg[gi] : pin_filt_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1_reg   <= '0;
            pin_s2_reg   <= '0;
            pin_s3_reg   <= '0;
            pin_filt_reg <= '0;
        end else begin
            pin_s1_reg   <= {sense_engaged_i, plant_flags_i};
            pin_s2_reg   <= pin_s1_reg;
            pin_s3_reg   <= pin_s2_reg;
            pin_filt_reg <= pin_filt_next;
        end
    end

    // ------------------------------------------------------------------------
    // Output state and current trip
    // ------------------------------------------------------------------------
    pmr_pkg::pmr_out_state_t state_reg;
    pmr_pkg::pmr_out_state_t state_next;
    logic [CNT_W-1:0]        trip_cnt_reg;
    logic [CNT_W-1:0]        trip_cnt_next;
    logic [31:0]             curr_tgt_reg;
    logic [31:0]             curr_tgt_next;
    logic [31:0]             volt_tgt_reg;
    logic [31:0]             volt_tgt_next;
    logic [31:0]             pwr_tgt_reg;
    logic [31:0]             pwr_tgt_next;
    logic [31:0]             trip_lim_reg;
    logic [31:0]             trip_lim_next;
    pmr_pkg::pmr_dec_t       dec;
    logic                    req_ok;
    logic                    over_sample;
    logic                    trip_hit;
    logic                    plant_fault;
    logic                    active;
    logic [63:0]             status_word;

    always_comb begin
        dec         = decode_req(req_i);
        req_ok      = req_valid_i && (dec.exc_code == `PMR_EXC_NONE);
        over_sample = meas_valid_i && fp_above(meas_i.current, trip_lim_reg);
        trip_hit    = (state_reg == pmr_pkg::OUT_LIVE) && over_sample && (trip_cnt_reg == TRIP_LAST);
        plant_fault = (pin_filt_reg[63:0] & `PMR_FAULT_MASK) != 64'h0;
        active      = (state_reg == pmr_pkg::OUT_LIVE) && !plant_fault;
    end

    always_comb begin
        state_next    = state_reg;
        trip_cnt_next = trip_cnt_reg;
        curr_tgt_next = curr_tgt_reg;
        volt_tgt_next = volt_tgt_reg;
        pwr_tgt_next  = pwr_tgt_reg;
        trip_lim_next = trip_lim_reg;
        if (meas_valid_i) begin
            trip_cnt_next = over_sample ? ((trip_cnt_reg == TRIP_LAST) ? trip_cnt_reg
                                                                        : trip_cnt_reg + 1'b1) : '0;
        end
        if (req_ok) begin
            unique case (dec.tgt)
                pmr_pkg::TGT_OUT_WR: begin
                    state_next    = req_i.wdata[0] ? pmr_pkg::OUT_LIVE : pmr_pkg::OUT_STANDBY;
                    trip_cnt_next = '0;
                end
                pmr_pkg::TGT_CURR_WR: curr_tgt_next = req_i.wdata;
                pmr_pkg::TGT_VOLT_WR: volt_tgt_next = req_i.wdata;
                pmr_pkg::TGT_PWR_WR:  pwr_tgt_next  = req_i.wdata;
                pmr_pkg::TGT_TRIP_WR: trip_lim_next = req_i.wdata;
                default: ;
            endcase
        end
        // Trip wins over a write in the same cycle
        if (trip_hit) begin
            state_next = pmr_pkg::OUT_TRIPPED;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg    <= pmr_pkg::OUT_STANDBY;
            trip_cnt_reg <= '0;
            curr_tgt_reg <= `PMR_TARGET_RESET;
            volt_tgt_reg <= `PMR_TARGET_RESET;
            pwr_tgt_reg  <= `PMR_TARGET_RESET;
            trip_lim_reg <= `PMR_TARGET_RESET;
        end else begin
            state_reg    <= state_next;
            trip_cnt_reg <= trip_cnt_next;
            curr_tgt_reg <= curr_tgt_next;
            volt_tgt_reg <= volt_tgt_next;
            pwr_tgt_reg  <= pwr_tgt_next;
            trip_lim_reg <= trip_lim_next;
        end
    end

    // ------------------------------------------------------------------------
    // Status word and response
    // ------------------------------------------------------------------------
    pmr_pkg::pmr_rsp_t rsp_reg;
    pmr_pkg::pmr_rsp_t rsp_next;
    logic              rsp_valid_reg;
    logic              rsp_valid_next;
    logic              pwr_en_reg;
    logic              pwr_en_next;

    always_comb begin
        // Filtered plant bits in PMR_STATUS_MASK pass, bits 0, 1 and 4 excepted; trips, protections, temperatures, boot and faults
        status_word = pin_filt_reg[63:0] & `PMR_STATUS_MASK;
        status_word[`PMR_BIT_STANDBY]   = !active;
        status_word[`PMR_BIT_LIVE]      = active;
        status_word[`PMR_BIT_CURR_TRIP] = (state_reg == pmr_pkg::OUT_TRIPPED);
    end

    always_comb begin
        rsp_next          = '0;
        rsp_next.func     = req_i.func;
        rsp_next.addr     = req_i.addr;
        rsp_next.count    = req_i.count;
        rsp_next.exc_code = dec.exc_code;
        rsp_next.exc      = (dec.exc_code != `PMR_EXC_NONE);
        if (rsp_next.exc) begin
            rsp_next.func = req_i.func | `PMR_EXC_FLAG;
        end else begin
            unique case (dec.tgt)
                pmr_pkg::TGT_STATUS:    rsp_next.rdata = status_word;
                pmr_pkg::TGT_OUT_WR:    rsp_next.rdata = {48'h0, req_i.wdata[15:0]};
                pmr_pkg::TGT_OUT_RD:    rsp_next.rdata = {63'h0, active};
                pmr_pkg::TGT_MEAS_CURR: rsp_next.rdata = {32'h0, meas_i.current};
                pmr_pkg::TGT_MEAS_VOLT: rsp_next.rdata = {32'h0, pin_filt_reg[FLAG_W] ? meas_i.sense_voltage
                                                                                    : meas_i.voltage};
                pmr_pkg::TGT_MEAS_PWR:  rsp_next.rdata = {32'h0, meas_i.power};
                pmr_pkg::TGT_CURR_RD:   rsp_next.rdata = {32'h0, curr_tgt_reg};
                pmr_pkg::TGT_VOLT_RD:   rsp_next.rdata = {32'h0, volt_tgt_reg};
                pmr_pkg::TGT_PWR_RD:    rsp_next.rdata = {32'h0, pwr_tgt_reg};
                pmr_pkg::TGT_TRIP_RD:   rsp_next.rdata = {32'h0, trip_lim_reg};
                default:                rsp_next.rdata = 64'h0;
            endcase
        end
        if (!req_valid_i) begin
            rsp_next = rsp_reg;
        end
        rsp_valid_next = req_valid_i;
        pwr_en_next    = (state_next == pmr_pkg::OUT_LIVE) && !plant_fault;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_reg       <= '0;
            rsp_valid_reg <= 1'b0;
            pwr_en_reg    <= 1'b0;
        end else begin
            rsp_reg       <= rsp_next;
            rsp_valid_reg <= rsp_valid_next;
            pwr_en_reg    <= pwr_en_next;
        end
    end

    assign rsp_o          = rsp_reg;
    assign rsp_valid_o    = rsp_valid_reg;
    assign power_enable_o = pwr_en_reg;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    a_status_reserved: assert property (
        rsp_valid_o && !rsp_o.exc && rsp_o.addr == `PMR_ADDR_STATUS
        |-> (rsp_o.rdata & ~`PMR_STATUS_MASK) == 64'h0)
        else $error("reserved status bits not zero");

    a_status_read_pure: assert property (
        req_valid_i && req_i.addr == `PMR_ADDR_STATUS && !over_sample
        |=> state_reg == $past(state_reg) && trip_lim_reg == $past(trip_lim_reg))
        else $error("status read changed state");

    a_standby_live: assert property (
        status_word[`PMR_BIT_STANDBY] != status_word[`PMR_BIT_LIVE])
        else $error("standby and live bits agree");

    a_answer_next: assert property (
        req_valid_i |=> rsp_valid_o && rsp_o.addr == $past(req_i.addr))
        else $error("no answer one cycle after request");

    a_answer_pulse: assert property (
        !req_valid_i |=> !rsp_valid_o)
        else $error("answer without request");

    a_bad_addr_exc: assert property (
        req_valid_i && dec.tgt == pmr_pkg::TGT_NONE && req_i.func == `PMR_FC_READ_HOLD && !trip_hit
        |=> rsp_o.exc && rsp_o.exc_code == `PMR_EXC_ADDR && state_reg == $past(state_reg))
        else $error("unmapped address not refused");

    a_exc_marked: assert property (
        rsp_valid_o && rsp_o.exc |-> rsp_o.func[7] && rsp_o.exc_code != `PMR_EXC_NONE)
        else $error("exception answer not marked");

    a_refused_keeps: assert property (
        req_valid_i && !req_ok
        |=> curr_tgt_reg == $past(curr_tgt_reg) && trip_lim_reg == $past(trip_lim_reg))
        else $error("refused request changed a target");

    a_output_on: assert property (
        req_ok && dec.tgt == pmr_pkg::TGT_OUT_WR && req_i.wdata[0] && !trip_hit
        |=> state_reg == pmr_pkg::OUT_LIVE)
        else $error("output did not switch on");

    a_output_off: assert property (
        req_ok && dec.tgt == pmr_pkg::TGT_OUT_WR && !req_i.wdata[0] && !trip_hit
        |=> state_reg == pmr_pkg::OUT_STANDBY && !power_enable_o)
        else $error("output did not switch off");

    a_fault_cuts: assert property (
        plant_fault |-> !active ##1 !power_enable_o)
        else $error("plant fault left output live");

    a_trip_count: assert property (
        trip_hit |=> state_reg == pmr_pkg::OUT_TRIPPED && !power_enable_o)
        else $error("trip not taken after consecutive samples");

    a_trip_holds_off: assert property (
        state_reg == pmr_pkg::OUT_TRIPPED
        |-> !active && !power_enable_o && status_word[`PMR_BIT_CURR_TRIP])
        else $error("tripped output still live");

    a_trip_clear: assert property (
        state_reg == pmr_pkg::OUT_TRIPPED && req_ok && dec.tgt == pmr_pkg::TGT_OUT_WR
        |=> !status_word[`PMR_BIT_CURR_TRIP])
        else $error("output write left trip flag set");

    a_target_store: assert property (
        req_ok && dec.tgt == pmr_pkg::TGT_CURR_WR |=> curr_tgt_reg == $past(req_i.wdata))
        else $error("current target not stored");

    a_meas_live: assert property (
        req_ok && dec.tgt == pmr_pkg::TGT_MEAS_CURR |=> rsp_o.rdata == {32'h0, $past(meas_i.current)})
        else $error("current reading not returned");

    a_bad_count: assert property (
        req_valid_i && req_i.addr == `PMR_ADDR_TRIP_WR && req_i.func == `PMR_FC_WRITE_MULTI
        && req_i.count != `PMR_CNT_VALUE
        |=> rsp_o.exc_code == `PMR_EXC_VALUE && trip_lim_reg == $past(trip_lim_reg))
        else $error("wrong count not refused");

    c_status_read: cover property (rsp_valid_o && !rsp_o.exc && rsp_o.addr == `PMR_ADDR_STATUS);
    c_trip:        cover property (state_reg == pmr_pkg::OUT_LIVE ##1 state_reg == pmr_pkg::OUT_TRIPPED);
    c_exception:   cover property (rsp_valid_o && rsp_o.exc);
    c_sense_volt:  cover property (rsp_valid_o && rsp_o.addr == `PMR_ADDR_MEAS_VOLT && pin_filt_reg[FLAG_W]);
    c_output_off:  cover property (state_reg == pmr_pkg::OUT_LIVE ##1 state_reg == pmr_pkg::OUT_STANDBY);

endmodule // pmr_regmap

`default_nettype wire

// File: core/pmr_defs.svh
// Register offsets, codes, field positions, reset values and counts of the supply register map
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PMR_ADDR_STATUS        16'h10d0
`define PMR_ADDR_OUT_WR        16'h10f0
`define PMR_ADDR_OUT_RD        16'h1100
`define PMR_ADDR_MEAS_CURR     16'h2010
`define PMR_ADDR_MEAS_VOLT     16'h2020
`define PMR_ADDR_MEAS_PWR      16'h2030
`define PMR_ADDR_CURR_WR       16'h3010
`define PMR_ADDR_CURR_RD       16'h3020
`define PMR_ADDR_VOLT_WR       16'h3030
`define PMR_ADDR_VOLT_RD       16'h3040
`define PMR_ADDR_PWR_WR        16'h3050
`define PMR_ADDR_PWR_RD        16'h3060
`define PMR_ADDR_TRIP_WR       16'h4010
`define PMR_ADDR_TRIP_RD       16'h4020

// ----------------------------------------------------------------------------
// Function and exception codes
// ----------------------------------------------------------------------------
`define PMR_FC_READ_HOLD       8'h03
`define PMR_FC_WRITE_SINGLE    8'h06
`define PMR_FC_WRITE_MULTI     8'h10
`define PMR_EXC_NONE           8'h00
`define PMR_EXC_FUNC           8'h01
`define PMR_EXC_ADDR           8'h02
`define PMR_EXC_VALUE          8'h03
`define PMR_EXC_FLAG           8'h80

// ----------------------------------------------------------------------------
// Register counts and values
// ----------------------------------------------------------------------------
`define PMR_CNT_STATUS         16'h0004
`define PMR_CNT_VALUE          16'h0002
`define PMR_CNT_SINGLE         16'h0001
`define PMR_OUT_OFF            16'h0000
`define PMR_OUT_ON             16'h0001
`define PMR_TARGET_RESET       32'h0000_0000

// ----------------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------------
`define PMR_BIT_STANDBY        0
`define PMR_BIT_LIVE           1
`define PMR_BIT_CURR_TRIP      4
`define PMR_STATUS_MASK        64'h0003_00f7_7fdf_fff3
`define PMR_FAULT_MASK         64'h0000_0000_0013_03e0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PMR_TRIP_SAMPLES       3

`endif

// File: core/pmr_pkg.sv
// Types shared by the supply register map
package pmr_pkg;

    typedef struct packed {
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] count;
        logic [31:0] wdata;
    } pmr_req_t;

    typedef struct packed {
        logic [7:0]  func;
        logic        exc;
        logic [7:0]  exc_code;
        logic [15:0] addr;
        logic [15:0] count;
        logic [63:0] rdata;
    } pmr_rsp_t;

    typedef struct packed {
        logic [31:0] current;
        logic [31:0] voltage;
        logic [31:0] sense_voltage;
        logic [31:0] power;
    } pmr_meas_t;

    typedef enum logic [1:0] {
        OUT_STANDBY,
        OUT_LIVE,
        OUT_TRIPPED
    } pmr_out_state_t;

    typedef enum logic [3:0] {
        TGT_STATUS,
        TGT_OUT_WR,
        TGT_OUT_RD,
        TGT_MEAS_CURR,
        TGT_MEAS_VOLT,
        TGT_MEAS_PWR,
        TGT_CURR_WR,
        TGT_CURR_RD,
        TGT_VOLT_WR,
        TGT_VOLT_RD,
        TGT_PWR_WR,
        TGT_PWR_RD,
        TGT_TRIP_WR,
        TGT_TRIP_RD,
        TGT_NONE
    } pmr_tgt_t;

    typedef struct packed {
        pmr_tgt_t    tgt;
        logic [7:0]  exc_code;
    } pmr_dec_t;

endpackage : pmr_pkg

// File: testbench/pmr_host_model.sv
// Host-side request model for the supply register map
`timescale 1ns/1ns
`default_nettype none
module pmr_host_model (
    input  wire logic              clk_i,
    input  wire logic              rsp_valid_i,
    input  wire pmr_pkg::pmr_rsp_t rsp_i,
    output logic                   req_valid_o,
    output pmr_pkg::pmr_req_t      req_o
);
    initial begin
        req_valid_o = 1'b0;
        req_o       = '0;
    end
    // One request pulse, then a fixed wait of four clock edges, keeping any answer seen
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c,
                        input logic [31:0] d, output pmr_pkg::pmr_rsp_t r);
        r = '1;
        req_o       <= '{f, a, c, d};
        req_valid_o <= 1'b1;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        req_o       <= ~req_o;
        repeat (4) begin
            @(posedge clk_i);
            if (rsp_valid_i === 1'b1) r = rsp_i;
        end
    endtask
endmodule // pmr_host_model
`default_nettype wire

// File: testbench/psu_modbus_register_map_tb.sv
// Self-checking bench for the supply register map
`timescale 1ns/1ns
`default_nettype none
`include "pmr_defs.svh"
module psu_modbus_register_map_tb;
    localparam int TS = 3;
    logic               clk_sys_i;
    logic               arst_n_i;
    logic               req_valid_i;
    pmr_pkg::pmr_req_t  req_i;
    logic               rsp_valid_o;
    pmr_pkg::pmr_rsp_t  rsp_o;
    logic [63:0]        plant_flags_i;
    logic               sense_engaged_i;
    logic               meas_valid_i;
    pmr_pkg::pmr_meas_t meas_i;
    logic               power_enable_o;
    pmr_pkg::pmr_rsp_t  rsp;
    logic [63:0]        prev;
    logic [15:0]        wa [4];
    int                 fail_count;
    int                 n_compared;

    pmr_regmap #(.TRIP_SAMPLES(TS), .FLAG_W(64)) dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
        .plant_flags_i(plant_flags_i), .sense_engaged_i(sense_engaged_i), .meas_valid_i(meas_valid_i),
        .meas_i(meas_i), .power_enable_o(power_enable_o));
    pmr_host_model u_host (.clk_i(clk_sys_i), .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o),
        .req_valid_o(req_valid_i), .req_o(req_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c, input logic [31:0] d);
        u_host.xfer(f, a, c, d, rsp);
    endtask
    task automatic ex(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c, input logic [31:0] d,
                      input logic [7:0] code);
        req(f, a, c, d);
        chk({rsp.exc, rsp.exc_code, rsp.func}, {1'b1, code, f | 8'h80});
    endtask
    task automatic meas(input logic [31:0] cur);
        meas_i.current <= cur;
        meas_valid_i   <= 1'b1;
        @(posedge clk_sys_i);
        meas_valid_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, wrong %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // --------------------------------
    // Tests
    // --------------------------------
    initial begin
        arst_n_i = 1'b0;
        plant_flags_i = '0;
        sense_engaged_i = 1'b0;
        meas_valid_i = 1'b0;
        meas_i = '{32'h3f80_0000, 32'h4120_0000, 32'h4110_0000, 32'h4220_0000};
        wa = '{16'h3010, 16'h3030, 16'h3050, 16'h4010};
        fail_count = 0;
        n_compared = 0;
        repeat (8) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        req(8'h03, 16'h10d0, 16'h0004, 32'h0);
        chk(rsp.rdata, 64'h1);
        chk({rsp.exc, rsp.func}, {1'b0, 8'h03});
        req(8'h03, 16'h1100, 16'h0001, 32'h0);
        chk(rsp.rdata, 64'h0);
        req(8'h06, 16'h10f0, 16'h0001, 32'h1);
        chk(power_enable_o, 1'b1);
        req(8'h03, 16'h1100, 16'h0001, 32'h0);
        chk(rsp.rdata, 64'h1);
        req(8'h03, 16'h10d0, 16'h0004, 32'h0);
        chk(rsp.rdata, 64'h2);
        $display("done: output switch");
        for (int i = 0; i < 4; i++) begin
            req(8'h10, wa[i], 16'h0002, 32'h40a0_0000 + 32'(i));
            chk({rsp.exc, rsp.addr, rsp.count}, {1'b0, wa[i], 16'h0002});
        end
        for (int i = 0; i < 4; i++) begin
            req(8'h03, wa[i] + 16'h0010, 16'h0002, 32'h0);
            chk(rsp.rdata, 64'h40a0_0000 + 64'(i));
        end
        $display("done: targets");
        ex(8'h04, 16'h10d0, 16'h0004, 32'h0, 8'h01);
        ex(8'h03, 16'h1234, 16'h0002, 32'h0, 8'h02);
        ex(8'h03, 16'h10d0, 16'h0002, 32'h0, 8'h03);
        ex(8'h03, 16'h3020, 16'h0004, 32'h0, 8'h03);
        ex(8'h10, 16'h3010, 16'h0004, 32'h1234_5678, 8'h03);
        ex(8'h10, 16'h4010, 16'h0001, 32'h1234_5678, 8'h03);
        ex(8'h10, 16'h3020, 16'h0002, 32'h1234_5678, 8'h02);
        ex(8'h06, 16'h10f0, 16'h0001, 32'h2, 8'h03);
        chk(power_enable_o, 1'b1);
        req(8'h03, 16'h3020, 16'h0002, 32'h0);
        chk(rsp.rdata, 64'h40a0_0000);
        $display("done: refusals");
        for (int b = 0; b < 64; b++) begin
            plant_flags_i <= 64'h1 << b;
            repeat (6) @(posedge clk_sys_i);
            req(8'h03, 16'h10d0, 16'h0004, 32'h0);
            chk(rsp.rdata & ~64'h13, (64'h1 << b) & `PMR_STATUS_MASK & ~64'h13);
        end
        plant_flags_i <= '1;
        repeat (6) @(posedge clk_sys_i);
        req(8'h03, 16'h10d0, 16'h0004, 32'h0);
        prev = rsp.rdata;
        req(8'h03, 16'h10d0, 16'h0004, 32'h0);
        chk(rsp.rdata, prev);
        chk(prev & ~64'h13, `PMR_STATUS_MASK & ~64'h13);
        req(8'h03, 16'h1100, 16'h0001, 32'h0);
        chk(rsp.rdata, 64'h0);
        chk(power_enable_o, 1'b0);
        plant_flags_i <= '0;
        repeat (6) @(posedge clk_sys_i);
        req(8'h03, 16'h10d0, 16'h0004, 32'h0);
        chk(rsp.rdata & ~64'h13, 64'h0);
        $display("done: status flags");
        req(8'h03, 16'h2010, 16'h0002, 32'h0);
        chk(rsp.rdata, 64'h3f80_0000);
        req(8'h03, 16'h2020, 16'h0002, 32'h0);
        chk(rsp.rdata, 64'h4120_0000);
        req(8'h03, 16'h2030, 16'h0002, 32'h0);
        chk(rsp.rdata, 64'h4220_0000);
        sense_engaged_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        req(8'h03, 16'h2020, 16'h0002, 32'h0);
        chk(rsp.rdata, 64'h4110_0000);
        $display("done: measurements");
        req(8'h06, 16'h10f0, 16'h0001, 32'h1);
        meas(32'h40c0_0000);
        meas(32'h40c0_0000);
        meas(32'h4080_0000);
        repeat (TS - 1) meas(32'h40c0_0000);
        chk(power_enable_o, 1'b1);
        meas(32'h40c0_0000);
        @(posedge clk_sys_i);
        chk(power_enable_o, 1'b0);
        req(8'h03, 16'h10d0, 16'h0004, 32'h0);
        chk(rsp.rdata[4], 1'b1);
        req(8'h06, 16'h10f0, 16'h0001, 32'h1);
        chk(power_enable_o, 1'b1);
        req(8'h06, 16'h10f0, 16'h0001, 32'h0);
        chk(power_enable_o, 1'b0);
        req(8'h03, 16'h10d0, 16'h0004, 32'h0);
        chk(rsp.rdata, 64'h1);
        $display("done: current trip");
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fail_count++;
        tally_and_finish();
    end
endmodule // psu_modbus_register_map_tb
`default_nettype wire
